// >>> src/branch_bitfield_divide_exec.sv
// Execute stage for branches, bit fields, divide, barrier and status returns
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "exec_unit_consts.svh"

module branch_bitfield_divide_exec
  import exec_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  // Issue from decode
  input  wire logic              issueValid,
  output logic                   issueReady,
  input  wire issue_s            issueInst,
  // Completion toward the register file
  output logic                   resValid,
  output result_s                res,
  // Control transfer toward fetch
  output logic                   redirect,
  output logic [31:0]            redirectPc,
  // Visible state
  output logic [31:0]            divHigh,
  output logic [31:0]            divLow,
  output logic                   divBusy,
  output logic                   debugMode,
  output logic                   interruptsOn,
  // AXI4-Lite slave
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp
);
  // ****************************************
  // Checks and helpers
  // ****************************************
  if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must hold the register map");
  end

  function automatic logic [31:0] signExtOffset(input logic [15:0] off);
    signExtOffset = {{`OFFSET_EXT_W{off[15]}}, off, 2'h0};
  endfunction

  function automatic logic [31:0] fieldMask(input logic [4:0] sizeM1);
    fieldMask = 32'hffff_ffff >> (5'h1f - sizeM1);
  endfunction

  function automatic logic [31:0] magnitude(input logic [31:0] x, input logic sgn);
    magnitude = (sgn && x[`SIGN_BIT]) ? 32'h0 - x : x;
  endfunction

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      old[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
    mergeBytes = old;
  endfunction

  logic [31:0] status;
  logic [31:0] excPc;
  logic [31:0] errPc;
  logic [31:0] dbgPc;
  logic        loadLinked;
  logic        slotPending;
  logic        slotTaken;
  logic        slotAnnul;
  logic [31:0] slotTarget;
  logic [5:0]  divCount;
  logic [31:0] divQ;
  logic [31:0] divR;
  logic [31:0] divD;
  logic        divNegQ;
  logic        divNegR;
  logic        accept;
  logic        suppress;
  logic        isDivide;
  logic        isBranch;
  logic        taken;
  logic        likely;
  logic [31:0] target;
  logic        execWr;
  logic [4:0]  execIdx;
  logic [31:0] execData;
  logic [32:0] shifted;
  logic [33:0] diff;
  logic [31:0] stepQ;
  logic [31:0] stepR;

  // ****************************************
  // Issue control
  // ****************************************
  assign isDivide = (issueInst.op == OP_SIGNED_DIVIDE) || (issueInst.op == OP_UNSIGNED_DIVIDE);
  // A divide in flight is the only hazard that outlives one cycle
  assign issueReady = !(divBusy && (isDivide || issueInst.op == OP_HAZARD_BARRIER));
  assign accept = issueValid && issueReady;
  assign suppress = slotPending && slotAnnul;

  always_comb begin
    isBranch = 1'b1;
    likely = 1'b0;
    taken = 1'b0;
    target = issueInst.pc + `SLOT_OFFSET + signExtOffset(issueInst.offset);
    case (issueInst.op)
      OP_BRANCH_IF_NEGATIVE, OP_BRANCH_IF_NEGATIVE_LINK: begin
        taken = issueInst.srcA[`SIGN_BIT];
      end
      OP_BRANCH_IF_NEGATIVE_LINK_LIKELY, OP_BRANCH_IF_NEGATIVE_LIKELY: begin
        taken = issueInst.srcA[`SIGN_BIT];
        likely = 1'b1;
      end
      OP_BRANCH_IF_NONPOSITIVE_LIKELY: begin
        taken = issueInst.srcA[`SIGN_BIT] || (issueInst.srcA == `ZERO_WORD);
        likely = 1'b1;
      end
      OP_BRANCH_IF_UNEQUAL: begin
        taken = issueInst.srcA != issueInst.srcB;
      end
      OP_BRANCH_IF_UNEQUAL_LIKELY: begin
        taken = issueInst.srcA != issueInst.srcB;
        likely = 1'b1;
      end
      OP_REGION_JUMP: begin
        taken = 1'b1;
        target = {issueInst.pc[`REGION_MSB:`REGION_LSB], issueInst.index, 2'h0};
      end
      default: begin
        isBranch = 1'b0;
      end
    endcase
  end

  always_comb begin
    execWr = 1'b1;
    execIdx = issueInst.dest;
    execData = status;
    case (issueInst.op)
      OP_BRANCH_IF_NEGATIVE_LINK, OP_BRANCH_IF_NEGATIVE_LINK_LIKELY: begin
        execIdx = `LINK_REG;
        execData = issueInst.pc + `LINK_OFFSET;
      end
      OP_INTERRUPT_DISABLE_ATOMIC, OP_INTERRUPT_ENABLE_ATOMIC: begin
        execData = status;
      end
      OP_FIELD_EXTRACT: begin
        execData = (issueInst.srcA >> issueInst.pos) & fieldMask(issueInst.sizeM1);
      end
      OP_FIELD_INSERT: begin
        execData = (issueInst.srcB & ~(fieldMask(issueInst.sizeM1) << issueInst.pos)) |
                   ((issueInst.srcA << issueInst.pos) &
                    (fieldMask(issueInst.sizeM1) << issueInst.pos));
      end
      default: begin
        execWr = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Delay slot and redirect
  // ****************************************
  // A branch sitting in a delay slot is not supported and simply replaces the pending one
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      slotPending <= 1'b0;
      slotTaken <= 1'b0;
      slotAnnul <= 1'b0;
      slotTarget <= `ZERO_WORD;
    end else if (accept) begin
      slotPending <= isBranch && !suppress;
      slotTaken <= taken;
      slotAnnul <= likely && !taken;
      slotTarget <= target;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      redirect <= 1'b0;
      redirectPc <= `ZERO_WORD;
    end else begin
      redirect <= 1'b0;
      if (accept && !suppress) begin
        if (slotPending && slotTaken) begin
          redirect <= 1'b1;
          redirectPc <= slotTarget;
        end
        if (issueInst.op == OP_RETURN_FROM_DEBUG) begin
          redirect <= 1'b1;
          redirectPc <= dbgPc;
        end
        if (issueInst.op == OP_RETURN_FROM_EXCEPTION) begin
          redirect <= 1'b1;
          redirectPc <= status[`STATUS_ERR_LV_BIT] ? errPc : excPc;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      resValid <= 1'b0;
      res <= '0;
    end else begin
      resValid <= accept;
      res.annulled <= suppress;
      res.wrEn <= accept && execWr && !suppress;
      res.wrIdx <= execIdx;
      res.wrData <= execData;
    end
  end

  // ****************************************
  // Status and saved program counters
  // ****************************************
  logic        doWrite;
  logic        awHeld;
  logic        wHeld;
  logic [ADDR_W-1:0] awAddrHeld;
  logic [31:0] wDataHeld;
  logic [3:0]  wStrbHeld;

  function automatic logic hitWrite(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hitWrite = a == ADDR_W'(off);
  endfunction

  // Instruction effects are placed last so they win over a same-cycle bus write
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      status <= `STATUS_RESET;
      loadLinked <= 1'b0;
      debugMode <= 1'b0;
    end else begin
      if (doWrite && hitWrite(awAddrHeld, `REG_STATUS)) begin
        status <= mergeBytes(status, wDataHeld, wStrbHeld);
      end
      if (doWrite && hitWrite(awAddrHeld, `REG_FLAGS) && wStrbHeld[0]) begin
        loadLinked <= wDataHeld[`FLAG_LOAD_LINK];
        debugMode <= wDataHeld[`FLAG_DEBUG_MODE];
      end
      if (accept && !suppress) begin
        case (issueInst.op)
          OP_INTERRUPT_DISABLE_ATOMIC: status[`STATUS_INT_EN_BIT] <= 1'b0;
          OP_INTERRUPT_ENABLE_ATOMIC: status[`STATUS_INT_EN_BIT] <= 1'b1;
          OP_RETURN_FROM_DEBUG: debugMode <= 1'b0;
          OP_RETURN_FROM_EXCEPTION: begin
            status[`STATUS_ERR_LV_BIT] <= 1'b0;
            loadLinked <= 1'b0;
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      excPc <= `ZERO_WORD;
      errPc <= `ZERO_WORD;
      dbgPc <= `ZERO_WORD;
    end else if (doWrite) begin
      if (hitWrite(awAddrHeld, `REG_EXC_PC)) excPc <= mergeBytes(excPc, wDataHeld, wStrbHeld);
      if (hitWrite(awAddrHeld, `REG_ERR_PC)) errPc <= mergeBytes(errPc, wDataHeld, wStrbHeld);
      if (hitWrite(awAddrHeld, `REG_DBG_PC)) dbgPc <= mergeBytes(dbgPc, wDataHeld, wStrbHeld);
    end
  end

  assign interruptsOn = status[`STATUS_INT_EN_BIT];

  // ****************************************
  // Iterative divider
  // ****************************************
  // One quotient bit per cycle keeps the array small at the cost of a long barrier stall
  assign shifted = {divR, divQ[31]};
  // Extra borrow bit, as the shifted remainder may already use bit 32
  assign diff = {1'b0, shifted} - {2'h0, divD};
  assign stepR = diff[33] ? shifted[31:0] : diff[31:0];
  assign stepQ = {divQ[30:0], !diff[33]};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      divBusy <= 1'b0;
      divCount <= 6'h0;
      divQ <= `ZERO_WORD;
      divR <= `ZERO_WORD;
      divD <= `ZERO_WORD;
      divNegQ <= 1'b0;
      divNegR <= 1'b0;
      divHigh <= `ZERO_WORD;
      divLow <= `ZERO_WORD;
    end else if (accept && !suppress && isDivide) begin
      divBusy <= 1'b1;
      divCount <= `DIV_STEPS;
      divQ <= magnitude(issueInst.srcA, issueInst.op == OP_SIGNED_DIVIDE);
      divD <= magnitude(issueInst.srcB, issueInst.op == OP_SIGNED_DIVIDE);
      divR <= `ZERO_WORD;
      divNegQ <= (issueInst.op == OP_SIGNED_DIVIDE) &&
                 (issueInst.srcA[`SIGN_BIT] ^ issueInst.srcB[`SIGN_BIT]);
      divNegR <= (issueInst.op == OP_SIGNED_DIVIDE) && issueInst.srcA[`SIGN_BIT];
    end else if (divBusy) begin
      divQ <= stepQ;
      divR <= stepR;
      divCount <= divCount - 6'h1;
      if (divCount == 6'h1) begin
        divBusy <= 1'b0;
        divLow <= divNegQ ? 32'h0 - stepQ : stepQ;
        divHigh <= divNegR ? 32'h0 - stepR : stepR;
      end
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  assign awready = !awHeld && !bvalid;
  assign wready = !wHeld && !bvalid;
  assign doWrite = awHeld && wHeld && !bvalid;
  assign arready = !rvalid;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrHeld <= '0;
      wDataHeld <= `ZERO_WORD;
      wStrbHeld <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        awAddrHeld <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld <= 1'b1;
        wDataHeld <= wdata;
        wStrbHeld <= wstrb;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (hitWrite(awAddrHeld, `REG_STATUS) || hitWrite(awAddrHeld, `REG_EXC_PC) ||
                  hitWrite(awAddrHeld, `REG_ERR_PC) || hitWrite(awAddrHeld, `REG_DBG_PC) ||
                  hitWrite(awAddrHeld, `REG_FLAGS)) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid <= 1'b0;
      rdata <= `ZERO_WORD;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= `RESP_OKAY;
      if (hitWrite(araddr, `REG_STATUS)) rdata <= status;
      else if (hitWrite(araddr, `REG_EXC_PC)) rdata <= excPc;
      else if (hitWrite(araddr, `REG_ERR_PC)) rdata <= errPc;
      else if (hitWrite(araddr, `REG_DBG_PC)) rdata <= dbgPc;
      else if (hitWrite(araddr, `REG_DIV_HIGH)) rdata <= divHigh;
      else if (hitWrite(araddr, `REG_DIV_LOW)) rdata <= divLow;
      else if (hitWrite(araddr, `REG_FLAGS)) rdata <= {29'h0, divBusy, debugMode, loadLinked};
      else begin
        rdata <= `ZERO_WORD;
        rresp <= `RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_live(op_e o);
    accept && !suppress && issueInst.op == o;
  endsequence
  sequence s_slot_taken;
    accept && !suppress && slotPending && slotTaken &&
    issueInst.op != OP_RETURN_FROM_DEBUG && issueInst.op != OP_RETURN_FROM_EXCEPTION;
  endsequence

  property p_neg_branch;
    s_live(OP_BRANCH_IF_NEGATIVE) |=> slotPending && (slotTaken == $past(issueInst.srcA[31]));
  endproperty
  a_neg_branch: assert property (p_neg_branch) else $error("negative branch decision wrong");
  property p_link;
    s_live(OP_BRANCH_IF_NEGATIVE_LINK) |=> res.wrEn && res.wrIdx == 5'h1f &&
      res.wrData == $past(issueInst.pc) + 32'h8;
  endproperty
  a_link: assert property (p_link) else $error("link write wrong");
  property p_annul;
    accept && slotPending && slotAnnul |=> resValid && res.annulled && !res.wrEn && !redirect;
  endproperty
  a_annul: assert property (p_annul) else $error("slot not annulled");
  property p_nonpos;
    s_live(OP_BRANCH_IF_NONPOSITIVE_LIKELY) && issueInst.srcA == 32'h0 |=> slotTaken && !slotAnnul;
  endproperty
  a_nonpos: assert property (p_nonpos) else $error("zero not taken");
  property p_unequal;
    s_live(OP_BRANCH_IF_UNEQUAL) |=> slotTaken == ($past(issueInst.srcA) != $past(issueInst.srcB));
  endproperty
  a_unequal: assert property (p_unequal) else $error("unequal decision wrong");
  property p_debug_ret;
    s_live(OP_RETURN_FROM_DEBUG) |=> redirect && redirectPc == $past(dbgPc) && !debugMode;
  endproperty
  a_debug_ret: assert property (p_debug_ret) else $error("debug return wrong");
  property p_int_off;
    s_live(OP_INTERRUPT_DISABLE_ATOMIC) |=> !interruptsOn && res.wrData == $past(status);
  endproperty
  a_int_off: assert property (p_int_off) else $error("atomic disable wrong");
  property p_int_on;
    s_live(OP_INTERRUPT_ENABLE_ATOMIC) |=> interruptsOn && res.wrData == $past(status);
  endproperty
  a_int_on: assert property (p_int_on) else $error("atomic enable wrong");
  property p_udiv;
    s_live(OP_UNSIGNED_DIVIDE) && issueInst.srcB != 32'h0 |-> ##33
      (divLow == $past(issueInst.srcA, 33) / $past(issueInst.srcB, 33)) &&
      (divHigh == $past(issueInst.srcA, 33) % $past(issueInst.srcB, 33)) && !divBusy;
  endproperty
  a_udiv: assert property (p_udiv) else $error("unsigned divide wrong");
  property p_sdiv;
    s_live(OP_SIGNED_DIVIDE) && issueInst.srcB != 32'h0 && issueInst.srcA != 32'h8000_0000
      |-> ##33 $signed(divLow) == $signed($past(issueInst.srcA, 33)) /
      $signed($past(issueInst.srcB, 33));
  endproperty
  a_sdiv: assert property (p_sdiv) else $error("signed divide wrong");
  property p_barrier;
    divBusy && issueValid && issueInst.op == OP_HAZARD_BARRIER |-> !issueReady;
  endproperty
  a_barrier: assert property (p_barrier) else $error("barrier issued under hazard");
  property p_exc_ret;
    s_live(OP_RETURN_FROM_EXCEPTION) && status[2] |=> redirect && redirectPc == $past(errPc)
      && !status[2] && !loadLinked;
  endproperty
  a_exc_ret: assert property (p_exc_ret) else $error("exception return wrong");
  property p_extract;
    s_live(OP_FIELD_EXTRACT) |=> res.wrData[0] == $past(issueInst.srcA[issueInst.pos]) &&
      ({1'b0, res.wrData} >> ($past(issueInst.sizeM1) + 6'h1)) == 33'h0;
  endproperty
  a_extract: assert property (p_extract) else $error("extract wrong");
  property p_insert;
    s_live(OP_FIELD_INSERT) |=> res.wrData[$past(issueInst.pos)] == $past(issueInst.srcA[0]);
  endproperty
  a_insert: assert property (p_insert) else $error("insert wrong");
  property p_jump;
    s_live(OP_REGION_JUMP) |=> slotTaken &&
      slotTarget == {$past(issueInst.pc[31:28]), $past(issueInst.index), 2'h0};
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");
  property p_slot;
    s_slot_taken |=> redirect && redirectPc == $past(slotTarget) && !res.annulled;
  endproperty
  a_slot: assert property (p_slot) else $error("delay slot transfer wrong");
  property p_offset;
    s_live(OP_BRANCH_IF_UNEQUAL) |=> slotTarget == $past(issueInst.pc) + 32'h4 +
      {{14{$past(issueInst.offset[15])}}, $past(issueInst.offset), 2'h0};
  endproperty
  a_offset: assert property (p_offset) else $error("branch offset wrong");
endmodule

// >>> src/exec_pkg.sv
// Types shared by the execute block and its bench
package exec_pkg;
  typedef enum logic [4:0] {
    OP_NONE,
    OP_BRANCH_IF_NEGATIVE,
    OP_BRANCH_IF_NEGATIVE_LINK,
    OP_BRANCH_IF_NEGATIVE_LINK_LIKELY,
    OP_BRANCH_IF_NEGATIVE_LIKELY,
    OP_BRANCH_IF_NONPOSITIVE_LIKELY,
    OP_BRANCH_IF_UNEQUAL,
    OP_BRANCH_IF_UNEQUAL_LIKELY,
    OP_REGION_JUMP,
    OP_RETURN_FROM_DEBUG,
    OP_INTERRUPT_DISABLE_ATOMIC,
    OP_INTERRUPT_ENABLE_ATOMIC,
    OP_SIGNED_DIVIDE,
    OP_UNSIGNED_DIVIDE,
    OP_HAZARD_BARRIER,
    OP_RETURN_FROM_EXCEPTION,
    OP_FIELD_EXTRACT,
    OP_FIELD_INSERT
  } op_e;

  typedef struct packed {
    op_e         op;
    logic [31:0] pc;
    logic [31:0] srcA;
    logic [31:0] srcB;
    logic [15:0] offset;
    logic [25:0] index;
    logic [4:0]  pos;
    logic [4:0]  sizeM1;
    logic [4:0]  dest;
  } issue_s;

  typedef struct packed {
    logic        annulled;
    logic        wrEn;
    logic [4:0]  wrIdx;
    logic [31:0] wrData;
  } result_s;
endpackage

// >>> src/exec_unit_consts.svh
// Register offsets, field positions and timing counts of the execute block
`ifndef EXEC_UNIT_CONSTS_SVH
`define EXEC_UNIT_CONSTS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define REG_STATUS        8'h00
`define REG_EXC_PC        8'h04
`define REG_ERR_PC        8'h08
`define REG_DBG_PC        8'h0c
`define REG_DIV_HIGH      8'h10
`define REG_DIV_LOW       8'h14
`define REG_FLAGS         8'h18
// ****************************************
// Field positions and reset values
// ****************************************
`define STATUS_INT_EN_BIT 0
`define STATUS_ERR_LV_BIT 2
`define FLAG_LOAD_LINK    0
`define FLAG_DEBUG_MODE   1
`define FLAG_DIV_BUSY     2
`define STATUS_RESET      32'h0000_0004
`define ZERO_WORD         32'h0000_0000
`define SIGN_BIT          31
`define REGION_MSB        31
`define REGION_LSB        28
`define OFFSET_EXT_W      14
// ****************************************
// Link, offsets and counts
// ****************************************
`define LINK_REG          5'h1f
`define LINK_OFFSET       32'h0000_0008
`define SLOT_OFFSET       32'h0000_0004
`define DIV_STEPS         6'h20
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

// >>> verif/fetch_model.sv
// Fetch side model that offers one instruction at a time
`timescale 1ns/100ps
module fetch_model
  import exec_pkg::*;
(
  // Clock, reset and bench request
  input  wire logic   core_clk,
  input  wire logic   arst_n,
  input  wire logic   start,
  input  wire issue_s nextInst,
  // Issue toward the block
  output logic        issueValid,
  input  wire logic   issueReady,
  output issue_s      issueInst
);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      issueValid <= 1'b0;
      issueInst  <= '0;
    end else if (issueValid && issueReady) begin
      // Scrambled once taken, so no stale word looks valid
      issueValid <= 1'b0;
      issueInst  <= ~issueInst;
    end else if (start && !issueValid) begin
      issueValid <= 1'b1;
      issueInst  <= nextInst;
    end
  end
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the execute block
`timescale 1ns/100ps
module tb_top
  import exec_pkg::*;
();
  logic        core_clk = 1'b0, arst_n = 1'b0, start = 1'b0, redir, issueValid, issueReady;
  logic        resValid, redirect, divBusy, debugMode, interruptsOn, awready, wready, bvalid;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        arready, rvalid;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, redirectPc, divHigh, divLow, rd;
  logic [1:0]  bresp, rresp, rr;
  issue_s      nxt = '0, issueInst;
  result_s     res, got;
  int          failures = 0, num_checks = 0;
  branch_bitfield_divide_exec dut_u (.core_clk, .arst_n, .issueValid, .issueReady, .issueInst,
    .resValid, .res, .redirect, .redirectPc, .divHigh, .divLow, .divBusy, .debugMode,
    .interruptsOn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
    .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
    .rvalid, .rready, .rdata, .rresp);
  fetch_model fm_u (.core_clk, .arst_n, .start, .nextInst(nxt), .issueValid, .issueReady,
    .issueInst);
  always #50 core_clk = ~core_clk;
  task automatic chk(input logic [79:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Each channel released at its own handshake edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic awHs, wHs, arHs, done;
    done = 1'b0;
    @(posedge core_clk);
    {awvalid, wvalid, bready, awaddr, wdata} <= {wr, wr, wr, a, d};
    {arvalid, rready, araddr} <= {!wr, !wr, a};
    for (int i = 0; i < 50 && !done; i++) begin
      // Settled values decide what the coming edge takes
      @(negedge core_clk);
      awHs = awvalid && awready;
      wHs = wvalid && wready;
      arHs = arvalid && arready;
      done = (bvalid && bready) || (rvalid && rready);
      {rd, rr} = {rdata, rresp};
      @(posedge core_clk);
      if (awHs) awvalid <= 1'b0;
      if (wHs) wvalid <= 1'b0;
      if (arHs) arvalid <= 1'b0;
    end
    {bready, rready} <= 2'b00;
    if (!done) failures++;
  endtask
  task automatic iss(input op_e o, input logic [31:0] a, b);
    @(posedge core_clk);
    nxt.op <= o;
    {nxt.srcA, nxt.srcB, start} <= {a, b, 1'b1};
    @(posedge core_clk);
    start <= 1'b0;
    for (int i = 0; i < 60 && !resValid; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk(resValid, 1'b1);
    {got, redir} = {res, redirect};
  endtask
  task automatic t_br();
    {nxt.pc, nxt.offset} <= {32'h0000_0100, 16'h0010};
    iss(OP_BRANCH_IF_NEGATIVE_LINK, 32'h8000_0000, 32'h0);
    chk({redir, got.wrEn, got.wrIdx, got.wrData}, {2'b01, 5'h1f, 32'h0000_0108});
    iss(OP_FIELD_EXTRACT, 32'h0, 32'h0);
    chk({redir, got.annulled, redirectPc}, {2'b10, 32'h0000_0144});
    iss(OP_BRANCH_IF_UNEQUAL_LIKELY, 32'h5, 32'h5);
    iss(OP_FIELD_EXTRACT, 32'h0, 32'h0);
    chk({redir, got.annulled, got.wrEn}, 3'b010);
    {nxt.pc, nxt.offset} <= {32'h0000_0200, 16'hfffe};
    iss(OP_BRANCH_IF_NONPOSITIVE_LIKELY, 32'h0, 32'h0);
    iss(OP_FIELD_EXTRACT, 32'h0, 32'h0);
    chk({redir, got.annulled, redirectPc}, {2'b10, 32'h0000_01fc});
    {nxt.pc, nxt.index} <= {32'ha000_0000, 26'h1};
    iss(OP_REGION_JUMP, 32'h0, 32'h0);
    iss(OP_FIELD_EXTRACT, 32'h0, 32'h0);
    chk({redir, redirectPc}, {1'b1, 32'ha000_0004});
  endtask
  task automatic t_calc();
    {nxt.pos, nxt.sizeM1} <= {5'h4, 5'h7};
    iss(OP_FIELD_EXTRACT, 32'habcd_1234, 32'h0);
    chk(got.wrData, 32'h0000_0023);
    nxt.pos <= 5'h8;
    iss(OP_FIELD_INSERT, 32'h0000_00ff, 32'h1234_5678);
    chk(got.wrData, 32'h1234_ff78);
    iss(OP_UNSIGNED_DIVIDE, 32'h64, 32'h7);
    iss(OP_HAZARD_BARRIER, 32'h0, 32'h0);
    chk({divBusy, divHigh, divLow}, {1'b0, 32'h2, 32'he});
    iss(OP_SIGNED_DIVIDE, 32'hffff_fff9, 32'h2);
    iss(OP_HAZARD_BARRIER, 32'h0, 32'h0);
    chk({divHigh, divLow}, {32'hffff_ffff, 32'hffff_fffd});
  endtask
  task automatic t_stat();
    iss(OP_INTERRUPT_ENABLE_ATOMIC, 32'h0, 32'h0);
    chk({got.wrData, interruptsOn}, {32'h0000_0004, 1'b1});
    iss(OP_INTERRUPT_DISABLE_ATOMIC, 32'h0, 32'h0);
    chk({got.wrData, interruptsOn}, {32'h0000_0005, 1'b0});
    bus(1'b1, 8'h08, 32'h0000_0300);
    bus(1'b1, 8'h04, 32'h0000_0400);
    bus(1'b1, 8'h0c, 32'h0000_0500);
    bus(1'b1, 8'h18, 32'h0000_0003);
    iss(OP_RETURN_FROM_EXCEPTION, 32'h0, 32'h0);
    chk({redir, redirectPc}, {1'b1, 32'h0000_0300});
    bus(1'b0, 8'h18, 32'h0);
    chk({rd, debugMode}, {32'h0000_0002, 1'b1});
    iss(OP_RETURN_FROM_EXCEPTION, 32'h0, 32'h0);
    chk(redirectPc, 32'h0000_0400);
    iss(OP_RETURN_FROM_DEBUG, 32'h0, 32'h0);
    chk({redir, redirectPc, debugMode}, {1'b1, 32'h0000_0500, 1'b0});
    bus(1'b0, 8'h40, 32'h0);
    chk({rr, rd}, {2'h2, 32'h0});
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    t_br();
    t_calc();
    t_stat();
    results();
  end
  initial begin
    #2000000;
    failures++;
    results();
  end
endmodule
